// ==== hw/mic_controller.sv ====
// Maskable interrupt controller: pin detection, flags, enables, priority and vectoring
`timescale 1ns/1ps
`default_nettype none
`include "mic_params.svh"

module mic_controller (
   input  wire logic                clk_in,          // Core clock
   input  wire logic                rst_n_in,        // Async reset, active low
   input  wire logic                ext_req_pin_zero_n_in, // External request pin 0
   input  wire logic                ext_req_pin_one_n_in,  // External request pin 1
   input  wire mic_pkg::mic_events_s events_in,      // Peripheral event pulses
   input  wire logic [7:0]          addr_in,         // Register address
   input  wire logic [7:0]          wdata_in,        // Write data
   input  wire logic                wr_in,           // Write strobe
   input  wire logic                rd_in,           // Read strobe
   output logic [7:0]               rdata_out,       // Read data, cycle after strobe
   input  wire logic                ack_in,          // Core takes the grant
   input  wire logic                reti_in,         // Core returns from a routine
   output mic_pkg::mic_grant_s      grant_out,       // Vector request
   output logic [4:0]               ca_module_flags_out // Counter array module flags
);
   import mic_pkg::*;

   // ============================================================================
   // Declarations
   logic [1:0]  sync_zero;                // Pin 0 synchroniser
   logic [1:0]  sync_one;                 // Pin 1 synchroniser
   logic [3:0]  win_cnt;                  // Sample window counter
   logic        win_tick;                 // One sample per window
   logic        samp_zero;                // Last sample, pin 0 (1 = high)
   logic        samp_one;                 // Last sample, pin 1
   logic [7:0]  irq_enable_reg;           // Enable register
   logic [6:0]  priority_high_reg;        // Level MSBs
   logic [6:0]  priority_low_reg;         // Level LSBs
   logic        ext_zero_edge_select;     // Pin 0 trigger select
   logic        ext_one_edge_select;      // Pin 1 trigger select
   logic        counter_overflow_irq_gate;// Counter array overflow gate
   logic [4:0]  module_event_irq_gate;    // Counter array module gates
   logic        ext_zero_req_flag;        // Pin 0 request flag
   logic        ext_one_req_flag;         // Pin 1 request flag
   logic        timer_zero_overflow_flag; // Timer 0 flag
   logic        timer_one_overflow_flag;  // Timer 1 flag
   logic        timer_two_overflow_flag;  // Timer 2 overflow flag
   logic        timer_two_capture_flag;   // Timer 2 capture flag
   logic        receive_done_flag;        // Serial receive flag
   logic        transmit_done_flag;       // Serial transmit flag
   logic        counter_array_overflow_flag; // Counter array overflow flag
   logic [4:0]  module_event_flag;        // Counter array module flags
   logic [3:0]  active_levels;            // Levels in service, one bit each
   logic [6:0]  src_req;                  // Raw request per source
   logic [6:0]  src_en;                   // Enabled request per source
   logic [6:0]  latched_req;              // Requests sampled this window
   mic_state_e  state;                    // Poll or request
   logic        hit;                      // Some source wins
   logic [2:0]  win_src;                  // Winning source
   logic [1:0]  win_lvl;                  // Winning level
   logic [2:0]  cur_lvl;                  // Active level plus one, 0 = none
   logic        det_zero;                 // Pin 0 activity this window
   logic        det_one;                  // Pin 1 activity this window
   logic        ack_go;                   // Grant acknowledged this cycle
   logic [2:0]  ack_src;                  // Source being acknowledged
   logic        wr_flags;                 // Software writes flags
   logic        wr_ctrl;                  // Software writes control

   // Vector table in source order
   function automatic logic [15:0] vec_of(input logic [2:0] s);
      unique case (s)
         3'h0: vec_of = `MIC_VEC_EXT0;
         3'h1: vec_of = `MIC_VEC_TIM0;
         3'h2: vec_of = `MIC_VEC_EXT1;
         3'h3: vec_of = `MIC_VEC_TIM1;
         3'h4: vec_of = `MIC_VEC_SERIAL;
         3'h5: vec_of = `MIC_VEC_TIM2;
         default: vec_of = `MIC_VEC_CA;
      endcase
   endfunction

   // ============================================================================
   // Pin synchronisers; first stage feeds only the second
   // Idle level on reset: no false request
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync_zero <= 2'h3;
         sync_one  <= 2'h3;
      end else begin
         sync_zero <= {sync_zero[0], ext_req_pin_zero_n_in};
         sync_one  <= {sync_one[0], ext_req_pin_one_n_in};
      end
   end

   // ============================================================================
   // Sample window: pins are looked at once every four state times
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         win_cnt <= 4'h0;
      end else if (win_cnt == 4'(`MIC_WINDOW_CYC - 1)) begin
         win_cnt <= 4'h0;
      end else begin
         win_cnt <= win_cnt + 4'h1;
      end
   end
   assign win_tick = (win_cnt == 4'(`MIC_WINDOW_CYC - 1));

   // Samples held between windows; reset high so no false edge
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         samp_zero <= 1'h1;
         samp_one  <= 1'h1;
      end else if (win_tick) begin
         samp_zero <= sync_zero[1];
         samp_one  <= sync_one[1];
      end
   end

   // Low level, or high-then-low across two samples. A pin held five
   // state times always spans one sample point, so it is never missed.
   // Edge mode needs a high sample first
   assign det_zero = win_tick && !sync_zero[1] &&
                     (!ext_zero_edge_select || samp_zero);
   assign det_one  = win_tick && !sync_one[1] &&
                     (!ext_one_edge_select || samp_one);

   // ============================================================================
   // Bus decode helpers
   assign wr_flags = wr_in && (addr_in == `MIC_ADDR_FLAGS);
   assign wr_ctrl  = wr_in && (addr_in == `MIC_ADDR_CTRL);
   assign ack_go   = ack_in && grant_out.valid;
   assign ack_src  = grant_out.source;

   // ============================================================================
   // Configuration registers
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_enable_reg            <= `MIC_RST_ENABLE;
         priority_high_reg         <= `MIC_RST_PRIO;
         priority_low_reg          <= `MIC_RST_PRIO;
         ext_zero_edge_select      <= 1'h0;
         ext_one_edge_select       <= 1'h0;
         counter_overflow_irq_gate <= 1'h0;
         module_event_irq_gate     <= 5'h00;
      end else if (wr_in) begin
         unique case (addr_in)
            `MIC_ADDR_ENABLE:    irq_enable_reg    <= wdata_in;
            `MIC_ADDR_PRIO_HIGH: priority_high_reg <= wdata_in[6:0];
            `MIC_ADDR_PRIO_LOW:  priority_low_reg  <= wdata_in[6:0];
            `MIC_ADDR_CTRL: begin
               ext_zero_edge_select      <= wdata_in[`MIC_CT_EXT0_EDGE];
               ext_one_edge_select       <= wdata_in[`MIC_CT_EXT1_EDGE];
               counter_overflow_irq_gate <= wdata_in[`MIC_CT_CA_OVF_GATE];
            end
            `MIC_ADDR_CA_GATE:   module_event_irq_gate <= wdata_in[4:0];
            default: ;                                         // Unmapped: ignored
         endcase
      end
   end

   // ============================================================================
   // Request flags: hardware set wins over software or vector clear
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ext_zero_req_flag        <= 1'h0;
         ext_one_req_flag         <= 1'h0;
         timer_zero_overflow_flag <= 1'h0;
         timer_one_overflow_flag  <= 1'h0;
         timer_two_overflow_flag  <= 1'h0;
         timer_two_capture_flag   <= 1'h0;
         receive_done_flag        <= 1'h0;
         transmit_done_flag       <= 1'h0;
      end else begin
         // Software write of the flag register sets or clears
         if (wr_flags) begin
            ext_zero_req_flag        <= wdata_in[`MIC_FL_EXT0];
            ext_one_req_flag         <= wdata_in[`MIC_FL_EXT1];
            timer_zero_overflow_flag <= wdata_in[`MIC_FL_TIM0];
            timer_one_overflow_flag  <= wdata_in[`MIC_FL_TIM1];
            timer_two_overflow_flag  <= wdata_in[`MIC_FL_T2OVF];
            timer_two_capture_flag   <= wdata_in[`MIC_FL_T2CAP];
            receive_done_flag        <= wdata_in[`MIC_FL_RX];
            transmit_done_flag       <= wdata_in[`MIC_FL_TX];
         end
         // Vector clear: edge pins and timers 0/1 only
         if (ack_go) begin
            if (ack_src == 3'h0 && ext_zero_edge_select) ext_zero_req_flag <= 1'h0;
            if (ack_src == 3'h2 && ext_one_edge_select)  ext_one_req_flag  <= 1'h0;
            if (ack_src == 3'h1) timer_zero_overflow_flag <= 1'h0;
            if (ack_src == 3'h3) timer_one_overflow_flag  <= 1'h0;
         end
         // Hardware sets last so they win; vectoring never clears 2/serial
         if (det_zero) ext_zero_req_flag <= 1'h1;
         if (det_one)  ext_one_req_flag  <= 1'h1;
         if (events_in.tim0_ovf && !events_in.tim0_mode3) timer_zero_overflow_flag <= 1'h1;
         if (events_in.tim1_ovf) timer_one_overflow_flag <= 1'h1;
         if (events_in.tim2_ovf) timer_two_overflow_flag <= 1'h1;
         if (events_in.tim2_cap) timer_two_capture_flag  <= 1'h1;
         if (events_in.rx_done)  receive_done_flag       <= 1'h1;
         if (events_in.tx_done)  transmit_done_flag      <= 1'h1;
      end
   end

   // Counter array flags, never cleared by vectoring
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         counter_array_overflow_flag <= 1'h0;
         module_event_flag           <= 5'h00;
      end else begin
         if (wr_ctrl) counter_array_overflow_flag <= wdata_in[`MIC_CT_CA_OVF];
         if (events_in.ca_ovf) counter_array_overflow_flag <= 1'h1;
         // A write and an event together keep the event
         module_event_flag <= (wr_in && addr_in == `MIC_ADDR_ACTIVE ? wdata_in[4:0]
                              : module_event_flag) | events_in.ca_module;
      end
   end

   // ============================================================================
   // Raw requests in within-level order, then enables
   assign src_req[0] = ext_zero_req_flag;
   assign src_req[1] = timer_zero_overflow_flag;
   assign src_req[2] = ext_one_req_flag;
   assign src_req[3] = timer_one_overflow_flag;
   assign src_req[4] = receive_done_flag | transmit_done_flag;
   assign src_req[5] = timer_two_overflow_flag | timer_two_capture_flag;
   assign src_req[6] = (counter_array_overflow_flag & counter_overflow_irq_gate) |
                       (|(module_event_flag & module_event_irq_gate));
   // Global bit gates all; bit order 0..6 matches sources
   assign src_en = src_req & irq_enable_reg[6:0] &
                   {7{irq_enable_reg[`MIC_EN_GLOBAL]}};

   // Requests are polled once per window, then resolved
   // Enables apply before the sample
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         latched_req <= 7'h00;
      end else if (win_tick) begin
         latched_req <= src_en;
      end
   end

   // ============================================================================
   // Resolver: highest level first, lowest index within a level
   always_comb begin
      hit     = 1'b0;
      win_src = 3'h0;
      win_lvl = 2'h0;
      for (int i = MIC_NSRC - 1; i >= 0; i--) begin
         // Still pending too: a flag cleared
         // since the sample must not win again
         if (latched_req[i] && src_en[i] &&
             (!hit || {priority_high_reg[i], priority_low_reg[i]} >= win_lvl)) begin
            hit     = 1'b1;
            win_src = 3'(i);
            win_lvl = {priority_high_reg[i], priority_low_reg[i]};
         end
      end
   end

   // Current in-service level plus one; zero means idle
   always_comb begin
      cur_lvl = 3'h0;
      for (int l = 0; l < 4; l++) begin
         if (active_levels[l]) cur_lvl = 3'(l + 1);
      end
   end

   // ============================================================================
   // Grant sequencing: one vector request per grant
   // Grant stands until the core takes it
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state     <= MIC_POLL;
         grant_out <= '0;
      end else begin
         unique case (state)
            MIC_POLL: begin
               // Strictly higher level only; level 3 blocks all
               if (win_tick && hit && ({1'b0, win_lvl} >= cur_lvl) &&
                   !active_levels[win_lvl]) begin
                  state            <= MIC_REQUEST;
                  grant_out.valid  <= 1'b1;
                  grant_out.source <= win_src;
                  grant_out.level  <= win_lvl;
                  grant_out.vector <= vec_of(win_src);
               end
            end
            MIC_REQUEST: begin
               if (ack_in) begin
                  state           <= MIC_POLL;
                  grant_out.valid <= 1'b0;
               end
            end
         endcase
      end
   end

   // Active levels: set on acknowledge, highest released on return
   // A return in an acknowledge cycle is lost
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         active_levels <= 4'h0;
      end else if (ack_go) begin
         active_levels[grant_out.level] <= 1'b1;
      end else if (reti_in && cur_lvl != 3'h0) begin
         active_levels[2'(cur_lvl - 3'h1)] <= 1'b0;
      end
   end

   // ============================================================================
   // Read port, data in the cycle after the strobe
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= 8'h00;
      end else if (rd_in) begin
         unique case (addr_in)
            `MIC_ADDR_ENABLE:    rdata_out <= irq_enable_reg;
            `MIC_ADDR_PRIO_HIGH: rdata_out <= {1'b0, priority_high_reg};
            `MIC_ADDR_PRIO_LOW:  rdata_out <= {1'b0, priority_low_reg};
            `MIC_ADDR_FLAGS:     rdata_out <= {timer_two_capture_flag, timer_two_overflow_flag,
                                               transmit_done_flag, receive_done_flag,
                                               timer_one_overflow_flag, ext_one_req_flag,
                                               timer_zero_overflow_flag, ext_zero_req_flag};
            `MIC_ADDR_CTRL:      rdata_out <= {4'h0, counter_overflow_irq_gate,
                                               counter_array_overflow_flag,
                                               ext_one_edge_select, ext_zero_edge_select};
            `MIC_ADDR_CA_GATE:   rdata_out <= {3'h0, module_event_irq_gate};
            `MIC_ADDR_ACTIVE:    rdata_out <= {active_levels, 4'h0} | {3'h0, module_event_flag};
            default:             rdata_out <= 8'h00;           // Unmapped reads zero
         endcase
      end
   end

   // Module flags shown to the counter array
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ca_module_flags_out <= 5'h00;
      end else begin
         ca_module_flags_out <= module_event_flag;
      end
   end

endmodule
`default_nettype wire

// ==== include/mic_params.svh ====
// Constants for the maskable interrupt controller: offsets, fields, resets and timing
// ============================================================================
// Function
// - Pin detect: low level or falling edge
// - Detection sets pin flag; enable gates it
// - Vectoring clears pin flag only if edge
// - Sample each pin once per window
// - Level held five states always detected
// - Timer 0/1 overflow flags, vector clears
// - Timer 2 request ORs two flags, kept
// - Counter array ORs six gated flags
// - Serial request ORs receive/transmit flags
// - Global enable gates every maskable source
// - Enable register layout, resets zero
// - Fixed vector address per source
// - Two-bit level from high/low bits
// - Priority bits 0..6 map sources
// - Pre-empt only by strictly higher level
// - Fixed order within equal level
// - Software may set or clear flags
// - Priority registers at B7/B8, reset zero
`ifndef MIC_PARAMS_SVH
`define MIC_PARAMS_SVH

// ============================================================================
// Register byte addresses
`define MIC_ADDR_ENABLE      8'hA8
`define MIC_ADDR_PRIO_HIGH   8'hB7
`define MIC_ADDR_PRIO_LOW    8'hB8
`define MIC_ADDR_FLAGS       8'hC0
`define MIC_ADDR_CTRL        8'hC1
`define MIC_ADDR_CA_GATE     8'hC2
`define MIC_ADDR_ACTIVE      8'hC3

// ============================================================================
// Reset values
`define MIC_RST_ENABLE       8'h00
`define MIC_RST_PRIO         7'h00

// ============================================================================
// Enable register fields
`define MIC_EN_GLOBAL        7

// Flag register fields (software view)
`define MIC_FL_EXT0          0
`define MIC_FL_TIM0          1
`define MIC_FL_EXT1          2
`define MIC_FL_TIM1          3
`define MIC_FL_RX            4
`define MIC_FL_TX            5
`define MIC_FL_T2OVF         6
`define MIC_FL_T2CAP         7

// Control register fields
`define MIC_CT_EXT0_EDGE     0
`define MIC_CT_EXT1_EDGE     1
`define MIC_CT_CA_OVF        2
`define MIC_CT_CA_OVF_GATE   3

// ============================================================================
// Timing: a state time is two oscillator periods; window is four state times
`define MIC_STATE_NS         16
`define MIC_CLK_NS           8
`define MIC_STATE_CYC        (`MIC_STATE_NS / `MIC_CLK_NS)
`define MIC_WINDOW_STATES    4
`define MIC_WINDOW_CYC       (`MIC_WINDOW_STATES * `MIC_STATE_CYC)

// ============================================================================
// Vector addresses
`define MIC_VEC_EXT0         16'h0003
`define MIC_VEC_TIM0         16'h000B
`define MIC_VEC_EXT1         16'h0013
`define MIC_VEC_TIM1         16'h001B
`define MIC_VEC_SERIAL       16'h0023
`define MIC_VEC_TIM2         16'h002B
`define MIC_VEC_CA           16'h0033

`endif

// ==== include/mic_pkg.sv ====
// Types shared by the maskable interrupt controller
package mic_pkg;

   // ============================================================================
   // Source count and index order (also the within-level order)
   localparam int MIC_NSRC = 7;

   // Hardware event pulses from the peripherals
   typedef struct packed {
      logic       tim0_ovf;     // Timer 0 overflow
      logic       tim0_mode3;   // Timer 0 in mode 3
      logic       tim1_ovf;     // Timer 1 overflow
      logic       tim2_ovf;     // Timer 2 overflow
      logic       tim2_cap;     // Timer 2 capture
      logic       rx_done;      // Serial receive done
      logic       tx_done;      // Serial transmit done
      logic       ca_ovf;       // Counter array overflow
      logic [4:0] ca_module;    // Counter array module events
   } mic_events_s;

   // Vector request toward the core
   typedef struct packed {
      logic        valid;       // Request pending
      logic [2:0]  source;      // Granted source index
      logic [1:0]  level;       // Its priority level
      logic [15:0] vector;      // Service routine address
   } mic_grant_s;

   // Controller sequencing
   typedef enum logic [1:0] {
      MIC_POLL,
      MIC_REQUEST
   } mic_state_e;

endpackage

// ==== verif/mic_assertions.sv ====
// Port checker for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module mic_assertions (
   input wire logic                clk_in,    // Clock
   input wire logic                rst_n_in,  // Reset
   input wire logic [7:0]          addr_in,   // Address
   input wire logic [7:0]          wdata_in,  // Write data
   input wire logic                wr_in,     // Write strobe
   input wire logic                rd_in,     // Read strobe
   input wire logic [7:0]          rdata_out, // Read data
   input wire logic                ack_in,    // Grant taken
   input wire mic_pkg::mic_grant_s grant_out  // Vector request
);
   import mic_pkg::*;
   logic [7:0] en;     // Enable shadow
   logic [6:0] ph, pl; // Priority shadows, bit 7 never kept
   logic [5:0] off;    // Cycles with global enable clear
   // ====
   // Shadows follow software writes
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         en <= 8'h00;
         ph <= 7'h00;
         pl <= 7'h00;
      end else if (wr_in) begin
         if (addr_in == 8'hA8) en <= wdata_in;
         if (addr_in == 8'hB7) ph <= wdata_in[6:0];
         if (addr_in == 8'hB8) pl <= wdata_in[6:0];
      end
   end
   // Cycles with global enable clear
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) off <= 6'h00;
      else if (en[7]) off <= 6'h00;
      else if (off != 6'h3F) off <= off + 6'h01;
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_pend; grant_out.valid && !ack_in; endsequence
   sequence s_take; grant_out.valid && ack_in; endsequence
   AST_HOLD: assert property (s_pend |=> grant_out.valid && $stable(grant_out))
      else $error("grant changed before ack");
   AST_DROP: assert property (s_take |=> !grant_out.valid)
      else $error("grant stayed after ack");
   AST_VEC: assert property (grant_out.valid |-> grant_out.source < 3'h7 &&
      grant_out.vector == 16'h0003 + {grant_out.source, 3'h0}) else $error("wrong vector");
   AST_LVL: assert property ($rose(grant_out.valid) |->
      grant_out.level == {ph[grant_out.source], pl[grant_out.source]}) else $error("wrong level");
   AST_EA: assert property ($rose(grant_out.valid) |-> off < 6'h02)
      else $error("grant while globally disabled");
   AST_RD_EN: assert property (rd_in && addr_in == 8'hA8 |=> rdata_out == en)
      else $error("enable readback wrong");
   AST_RD_PRIO: assert property (rd_in && addr_in == 8'hB7 |=> rdata_out == {1'b0, ph})
      else $error("priority readback wrong");
   AST_RD_NONE: assert property (rd_in && addr_in == 8'h00 |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
endmodule
bind mic_controller mic_assertions i_chk (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in,
   .rd_in, .rdata_out, .ack_in, .grant_out);
`default_nettype wire

// ==== verif/mic_core_model.sv ====
// Core model: takes each vector request after a prompt or slow delay
`timescale 1ns/1ps
`default_nettype none
module mic_core_model (
   input  wire logic                clk_in,   // Clock
   input  wire logic                rst_n_in, // Reset
   input  wire mic_pkg::mic_grant_s grant_in, // Vector request
   input  wire logic                slow_in,  // Take grants late
   output logic                     ack_out   // Grant taken, one pulse
);
   import mic_pkg::*;
   logic [3:0] wait_cnt; // Cycles the request has stood
   // One acknowledge per grant; no second pulse while it drops
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wait_cnt <= 4'h0;
         ack_out  <= 1'b0;
      end else begin
         ack_out  <= grant_in.valid && !ack_out && wait_cnt >= (slow_in ? 4'hA : 4'h1);
         wait_cnt <= (grant_in.valid && !ack_out) ? wait_cnt + 4'h1 : 4'h0;
      end
   end
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb;
   import mic_pkg::*;
   logic        clk_in, rst_n_in, pin0, pin1, wr_in, rd_in, ack_in, reti_in, slow_in; // Drives
   logic [7:0]  addr_in, wdata_in, rdata_out; // Register port
   mic_events_s events_in;                    // Event pulses
   mic_grant_s  grant_out;                    // Vector request
   logic [4:0]  ca_flags;                     // Module flags
   int          mismatches, num_checks, acks, i; // Tallies
   mic_controller i_dut (.clk_in, .rst_n_in, .ext_req_pin_zero_n_in(pin0), .ext_req_pin_one_n_in(pin1),
      .events_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .ack_in, .reti_in, .grant_out,
      .ca_module_flags_out(ca_flags));
   mic_core_model i_core (.clk_in, .rst_n_in, .grant_in(grant_out), .slow_in, .ack_out(ack_in));
   // ====
   // Clock, grant tally and hang guard
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   always @(posedge clk_in) if (ack_in === 1'b1) acks++;
   initial begin
      repeat (20000) @(posedge clk_in);
      mismatches++;
      print_verdict();
   end
   task automatic print_verdict();
      if (mismatches == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   // Data stand from the cycle after the strobe until the next read
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 chk("rdata", {8'h00, e}, {8'h00, rdata_out});
   endtask
   task automatic pulse(input mic_events_s e);
      @(posedge clk_in);
      events_in <= e;
      @(posedge clk_in);
      events_in <= '0;
   endtask
   task automatic ret();
      @(posedge clk_in);
      reti_in <= 1'b1;
      @(posedge clk_in);
      reti_in <= 1'b0;
   endtask
   // Wait for a grant, compare it, let the core take it
   task automatic gnt(input logic [15:0] v, input logic [1:0] l);
      for (int k = 0; k < 80 && grant_out.valid !== 1'b1; k++) @(negedge clk_in);
      chk("vector", v, grant_out.valid ? grant_out.vector : 16'h0000);
      chk("level", {14'h0, l}, {14'h0, grant_out.level});
      for (int k = 0; k < 20 && grant_out.valid !== 1'b0; k++) @(negedge clk_in);
   endtask
   task automatic none(input int n);
      int a;
      a = acks;
      repeat (n) @(negedge clk_in);
      chk("grants", 16'(a), 16'(acks));
   endtask
   // ====
   // Main sequence
   initial begin
      rst_n_in = 1'b0;
      {pin0, pin1, wr_in, rd_in, reti_in, slow_in} = 6'b110000;
      {addr_in, wdata_in} = 16'h0000;
      events_in = '0;
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(8'hA8, 8'h00);
      rd(8'hB8, 8'h00);
      rd(8'h00, 8'h00);
      wr(8'hB7, 8'h7F);
      rd(8'hB7, 8'h7F);
      wr(8'hB7, 8'h00);
      wr(8'hC1, 8'h03);
      wr(8'hA8, 8'hFF);
      wr(8'hC0, 8'h0F);
      for (i = 0; i < 4; i++) begin
         gnt(16'h0003 + 16'(8 * i), 2'h0);
         ret();
      end
      rd(8'hC0, 8'h00);
      slow_in <= 1'b1;
      for (i = 0; i < 2; i++) begin
         pulse(i ? 13'h0100 : 13'h0080);
         gnt(i ? 16'h002B : 16'h0023, 2'h0);
         rd(8'hC0, i ? 8'h80 : 8'h10);
         wr(8'hC0, 8'h00);
         ret();
      end
      slow_in <= 1'b0;
      pulse(13'h1800);
      none(40);
      pulse(13'h1000);
      gnt(16'h000B, 2'h0);
      rd(8'hC0, 8'h00);
      ret();
      wr(8'hA8, 8'h7F);
      wr(8'hC0, 8'h08);
      none(48);
      wr(8'hA8, 8'hFF);
      gnt(16'h001B, 2'h0);
      ret();
      wr(8'hC0, 8'h01);
      gnt(16'h0003, 2'h0);
      wr(8'hB8, 8'h0A);
      wr(8'hC0, 8'h08);
      gnt(16'h001B, 2'h1);
      wr(8'hC0, 8'h02);
      none(48);
      ret();
      gnt(16'h000B, 2'h1);
      ret();
      ret();
      pin0 <= 1'b0;
      repeat (24) @(posedge clk_in);
      pin0 <= 1'b1;
      gnt(16'h0003, 2'h0);
      ret();
      wr(8'hC1, 8'h01);
      pin1 <= 1'b0;
      gnt(16'h0013, 2'h0);
      rd(8'hC0, 8'h04);
      pin1 <= 1'b1;
      repeat (40) @(posedge clk_in);
      wr(8'hC0, 8'h00);
      ret();
      none(48);
      wr(8'hC2, 8'h01);
      pulse(13'h0001);
      gnt(16'h0033, 2'h0);
      chk("ca_flags", 16'h0001, {11'h0, ca_flags});
      wr(8'hC3, 8'h00);
      ret();
      print_verdict();
   end
endmodule
`default_nettype wire
